/* File: src/anc_pkg.sv */
// constants and types for the auto-negotiation receive checker
package anc_pkg;
	localparam int CLK_MHZ         = 200;
	// times in microseconds (pulse level) and milliseconds (burst level)
	localparam int FLP_MIN_US      = 15;
	localparam int FLP_MAX_US      = 175;
	localparam int DATA_MIN_US     = 31;
	localparam int DATA_MAX_US     = 89;
	localparam int NLP_MIN_MS      = 6;
	localparam int NLP_MAX_MS      = 100;
	localparam int BREAK_MS        = 1350;
	localparam int FLP_MIN_CYC     = FLP_MIN_US * CLK_MHZ;
	localparam int FLP_MAX_CYC     = FLP_MAX_US * CLK_MHZ;
	localparam int DATA_MIN_CYC    = DATA_MIN_US * CLK_MHZ;
	localparam int DATA_MAX_CYC    = DATA_MAX_US * CLK_MHZ;
	localparam int NLP_MIN_CYC     = NLP_MIN_MS * 1000 * CLK_MHZ;
	localparam int NLP_MAX_CYC     = NLP_MAX_MS * 1000 * CLK_MHZ;
	localparam int BREAK_CYC       = BREAK_MS * 1000 * CLK_MHZ;
	localparam int ABLE_PULSES     = 6;
	localparam int ABLE_PULSES_MAX = 17;
	localparam int MATCH_NEEDED    = 3;
	localparam int WORD_BITS       = 16;
	localparam int ACK_BIT         = 14;
	localparam int CW              = 32;

	typedef enum logic [1:0] {
		ANC_IDLE    = 2'b00,
		ANC_ABILITY = 2'b01,
		ANC_ACKDET  = 2'b10,
		ANC_TXDIS   = 2'b11
	} anc_arb_t;

	typedef enum logic [1:0] {
		ANC_RX_WAIT  = 2'b00,
		ANC_RX_CLOCK = 2'b01,
		ANC_RX_DATA  = 2'b10
	} anc_rx_t;
endpackage : anc_pkg

/* File: src/anc_flp_rx_check.sv */
// receive-side burst timing, word decoding and consistency checking
module anc_flp_rx_check import anc_pkg::*; #(
	// terminal counts in ref_clk cycles, each inside its required range
	parameter int FLP_MIN   = FLP_MIN_CYC,
	parameter int FLP_MAX   = FLP_MAX_CYC,
	parameter int DATA_MIN  = DATA_MIN_CYC,
	parameter int DATA_MAX  = DATA_MAX_CYC,
	parameter int NLP_MIN   = NLP_MIN_CYC,
	parameter int NLP_MAX   = NLP_MAX_CYC,
	parameter int BREAK_LEN = BREAK_CYC
) (
	// clocks and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 link_clk,
	// pulse level from the wire
	input  wire logic                 link_pulse,
	// negotiation status, all registered
	output logic                      partner_able,
	output logic                      ack_detect,
	output logic                      ack_complete,
	output logic                      tx_enable,
	output logic                      restart_burst,
	output logic                      mismatch,
	output logic [WORD_BITS-1:0]      rx_word
);
	// link side: catch pulse edges on the link clock, hand over by toggle
	// a toggle survives the clock crossing where a one-cycle strobe would be lost
	typedef struct packed {
		logic [1:0] rsync;
		logic [1:0] sync;
		logic       prev;
		logic       tog;
	} anc_link_st_t;

	anc_link_st_t lk, next_lk;
	logic         link_rise;
	logic         link_rst;

	always_comb begin
		link_rise    = lk.sync[1] && !lk.prev;
		link_rst     = lk.rsync[1];
		next_lk      = lk;
		next_lk.sync = {lk.sync[0], link_pulse};
		next_lk.prev = lk.sync[1];
		if (link_rise) begin
			next_lk.tog = ~lk.tog;
		end
		if (link_rst) begin
			next_lk.sync = '0;
			next_lk.prev = 1'b0;
			next_lk.tog  = 1'b0;
		end
		// reset of the link domain, brought across as a level
		next_lk.rsync = {lk.rsync[0], rst};
	end

	always_ff @(posedge link_clk) begin
		lk <= next_lk;
	end

	typedef struct packed {
		// pulse timing, arbitration state and break count
		logic [2:0]           tsync;
		anc_rx_t              rx;
		anc_arb_t             arb;
		logic [CW-1:0]        gap;
		logic [CW-1:0]        bgap;
		logic [CW-1:0]        brk;

		// word assembly
		logic [4:0]           pcnt;
		logic [4:0]           bits;
		logic [WORD_BITS-1:0] shreg;
		logic [WORD_BITS-1:0] ref_word;
		logic [WORD_BITS-1:0] last_word;
		logic [1:0]           match;
		logic                 bad;
		logic                 late_gap;
		logic                 seen_burst;

		// registered outputs
		logic                 partner_able;
		logic                 ack_detect;
		logic                 ack_complete;
		logic                 tx_enable;
		logic                 restart_burst;
		logic                 mismatch;
		logic [WORD_BITS-1:0] rx_word;
	} anc_st_t;

	anc_st_t s, n;

	// sizes of the small counters taken from the package constants
	localparam logic [4:0] BITS_FULL  = 5'(WORD_BITS);
	localparam logic [4:0] ABLE_LO    = 5'(ABLE_PULSES);
	localparam logic [4:0] ABLE_HI    = 5'(ABLE_PULSES_MAX);
	localparam logic [1:0] MATCH_LAST = 2'(MATCH_NEEDED - 1);

	function automatic logic [CW-1:0] inc_sat(input logic [CW-1:0] v);
		return (v == {CW{1'b1}}) ? v : v + 1'b1;
	endfunction : inc_sat

	// the acknowledge bit changes during negotiation, so it is masked
	function automatic logic same_word(input logic [WORD_BITS-1:0] a,
		input logic [WORD_BITS-1:0] b);
		logic [WORD_BITS-1:0] m;
		m          = '1;
		m[ACK_BIT] = 1'b0;
		return ((a & m) == (b & m));
	endfunction : same_word

	// five-bit counters stop at their top value instead of wrapping
	function automatic logic [4:0] inc_sat5(input logic [4:0] v);
		return (&v) ? v : v + 5'h01;
	endfunction : inc_sat5

	// gap classes seen from the previous pulse
	function automatic logic too_close(input logic [CW-1:0] g);
		return (g < CW'(FLP_MIN));
	endfunction : too_close

	function automatic logic data_early(input logic [CW-1:0] g);
		return (g < CW'(DATA_MIN));
	endfunction : data_early

	function automatic logic data_late(input logic [CW-1:0] g);
		return (g >= CW'(DATA_MAX));
	endfunction : data_late

	function automatic logic burst_over(input logic [CW-1:0] g);
		return (g >= CW'(FLP_MAX));
	endfunction : burst_over

	logic pulse;
	logic burst_end;
	logic [WORD_BITS-1:0] word;

	// decodes of the state shared by the burst and arbitration logic
	logic       word_ok;
	logic       same_last;
	logic       same_ref;
	logic       ack_set;
	logic       brk_done;
	logic       nlp_early;
	logic       nlp_late;
	logic       able_now;
	logic [1:0] match_in;

	assign word_ok   = !s.bad && (s.bits >= BITS_FULL);
	assign same_last = same_word(s.shreg, s.last_word);
	assign same_ref  = same_word(s.shreg, s.ref_word);
	assign ack_set   = s.shreg[ACK_BIT];
	assign brk_done  = (s.brk >= CW'(BREAK_LEN - 1));
	assign nlp_early = s.seen_burst && (s.bgap < CW'(NLP_MIN));
	assign nlp_late  = s.seen_burst && (s.bgap > CW'(NLP_MAX));
	assign able_now  = (s.pcnt >= ABLE_LO) && (s.pcnt <= ABLE_HI) && !s.bad;
	// a long silence starts the consistency count again
	assign match_in  = s.late_gap ? 2'b00 : s.match;

	always_comb begin
		n     = s;
		// each toggle from the link domain marks one received pulse
		pulse = s.tsync[2] ^ s.tsync[1];
		word  = s.shreg;
		n.tsync         = {s.tsync[1:0], lk.tog};
		n.gap           = inc_sat(s.gap);
		n.bgap          = inc_sat(s.bgap);
		n.restart_burst = 1'b0;
		burst_end       = 1'b0;

		// pulse timing within a burst
		unique case (s.rx)
			ANC_RX_WAIT: begin
				if (pulse) begin
					n.rx    = ANC_RX_CLOCK;
					n.gap   = '0;
					n.pcnt  = 5'h01;
					n.bits  = '0;
					n.shreg = '0;
					n.bad      = nlp_early;
					n.late_gap = nlp_late;
				end
			end
			ANC_RX_CLOCK: begin
				// waiting for data after a clock pulse
				if (pulse) begin
					if (too_close(s.gap) || data_early(s.gap)) begin
						n.bad = 1'b1;
					end else if (!data_late(s.gap)) begin
						n.rx = ANC_RX_DATA;
						if (s.bits < BITS_FULL) begin
							n.shreg[s.bits[3:0]] = 1'b1;
						end
						n.bits = inc_sat5(s.bits);
					end else begin
						// late pulse counts as next clock, bit was zero
						n.bits = inc_sat5(s.bits);
					end
					n.gap  = '0;
					n.pcnt = inc_sat5(s.pcnt);
				end else if (burst_over(s.gap)) begin
					burst_end = 1'b1;
				end
			end
			ANC_RX_DATA: begin
				// a pulse after a data pulse is always the next clock
				if (pulse) begin
					if (too_close(s.gap)) begin
						n.bad = 1'b1;
					end
					n.rx   = ANC_RX_CLOCK;
					n.gap  = '0;
					n.pcnt = inc_sat5(s.pcnt);
				end else if (burst_over(s.gap)) begin
					burst_end = 1'b1;
				end
			end
			default: n.rx = ANC_RX_WAIT;
		endcase

		// latched at the sixth clean pulse, never later than the seventeenth
		if (able_now && !s.partner_able) begin
			n.partner_able = 1'b1;
		end

		// word acceptance and arbitration, once per finished burst
		if (burst_end) begin
			n.rx         = ANC_RX_WAIT;
			n.bgap       = '0;
			n.seen_burst = 1'b1;
			n.match      = match_in;
			// incomplete or badly spaced bursts are dropped
			if (!word_ok) begin
				n.match = '0;
			end else begin
				n.last_word = word;
				n.rx_word   = word;
				unique case (s.arb)
					ANC_IDLE, ANC_ABILITY: begin
						n.arb = ANC_ABILITY;
						if (match_in != 2'b00 && !same_last) begin
							n.match = 2'b01;
						end else if (match_in == MATCH_LAST) begin
							n.arb        = ANC_ACKDET;
							n.ack_detect = 1'b1;
							n.ref_word   = word;
							n.match      = '0;
						end else begin
							n.match = match_in + 2'b01;
						end
					end
					ANC_ACKDET: begin
						if (!same_ref) begin
							n.arb        = ANC_TXDIS;
							n.tx_enable  = 1'b0;
							n.mismatch   = 1'b1;
							n.brk        = '0;
							n.ack_detect = 1'b0;
						end else if (!ack_set) begin
							n.match = '0;
						end else if (match_in == MATCH_LAST) begin
							n.ack_complete = 1'b1;
						end else begin
							n.match = match_in + 2'b01;
						end
					end
					ANC_TXDIS: begin
						// bursts heard while silent leave the arbitration state alone; rx_word and last_word still update
					end
				endcase
			end
		end

		// break-link wait: transmit stays off for the whole count
		if (s.arb == ANC_TXDIS) begin
			n.brk = inc_sat(s.brk);
			if (brk_done) begin
				// restart negotiation with a fresh first burst
				n.arb           = ANC_IDLE;
				n.tx_enable     = 1'b1;
				n.restart_burst = 1'b1;
				n.mismatch      = 1'b0;
				n.match         = '0;
				n.ack_complete  = 1'b0;
				n.partner_able  = 1'b0;
				n.seen_burst    = 1'b0;
			end
		end

		// tx_enable is the only field that comes out of reset high
		if (rst) begin
			n.tsync         = '0;
			n.rx            = ANC_RX_WAIT;
			n.arb           = ANC_IDLE;
			n.gap           = '0;
			n.bgap          = '0;
			n.brk           = '0;
			n.pcnt          = '0;
			n.bits          = '0;
			n.shreg         = '0;
			n.ref_word      = '0;
			n.last_word     = '0;
			n.match         = '0;
			n.bad           = 1'b0;
			n.late_gap      = 1'b0;
			n.seen_burst    = 1'b0;
			n.partner_able  = 1'b0;
			n.ack_detect    = 1'b0;
			n.ack_complete  = 1'b0;
			n.tx_enable     = 1'b1;
			n.restart_burst = 1'b0;
			n.mismatch      = 1'b0;
			n.rx_word       = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		s <= n;
	end

	// outputs come straight from the state register
	assign partner_able  = s.partner_able;
	assign ack_detect    = s.ack_detect;
	assign ack_complete  = s.ack_complete;
	assign tx_enable     = s.tx_enable;
	assign restart_burst = s.restart_burst;
	assign mismatch      = s.mismatch;
	assign rx_word       = s.rx_word;
endmodule : anc_flp_rx_check

/* File: verification/anc_chk_props.sv */
// assertion checker on the receive checker ports
module anc_chk import anc_pkg::*; #(
	parameter int BREAK_LEN = BREAK_CYC
) (
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire logic                 link_clk,
	input wire logic                 link_pulse,
	input wire logic                 partner_able,
	input wire logic                 ack_detect,
	input wire logic                 ack_complete,
	input wire logic                 tx_enable,
	input wire logic                 restart_burst,
	input wire logic                 mismatch,
	input wire logic [WORD_BITS-1:0] rx_word
);
	// length of the current mismatch run, read back at restart
	int brk_cnt;
	always_ff @(posedge ref_clk) begin
		if (rst || !mismatch) brk_cnt <= 0;
		else brk_cnt <= brk_cnt + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	tx_stop_a: assert property (mismatch |-> !tx_enable) else $error("tx on in mismatch");
	mis_cause_a: assert property ($rose(mismatch) |-> $past(ack_detect))
		else $error("mismatch outside ack detect");
	restart_a: assert property (restart_burst |-> $past(mismatch) && !mismatch && tx_enable)
		else $error("bad restart");
	mis_hold_a: assert property ($fell(mismatch) |-> restart_burst) else $error("flag dropped");
	break_len_a: assert property (restart_burst |-> brk_cnt inside {[BREAK_LEN-2:BREAK_LEN+2]})
		else $error("break wait length wrong");
	able_first_a: assert property ($rose(ack_detect) |-> partner_able) else $error("not able");
	ack_done_a: assert property ($rose(ack_complete) |-> $past(ack_detect))
		else $error("complete without ack detect");
	quiet_end_a: assert property ($rose(ack_detect) |-> !$past(link_pulse, 40))
		else $error("ack detect inside a burst");
	cover property ($rose(ack_detect));
	cover property ($rose(ack_complete));
	cover property (restart_burst);
endmodule : anc_chk

bind anc_flp_rx_check anc_chk #(.BREAK_LEN(BREAK_LEN)) i_chk (
	.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .link_pulse(link_pulse),
	.partner_able(partner_able), .ack_detect(ack_detect), .ack_complete(ack_complete),
	.tx_enable(tx_enable), .restart_burst(restart_burst), .mismatch(mismatch),
	.rx_word(rx_word));

/* File: verification/anc_lp_model.sv */
// far-end partner that sends one burst of clock and data pulses
module anc_lp_model (
	output logic link_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	initial link_pulse = 1'b0;
	// 15 ns keeps the pulse over two link clock edges
	task automatic pulse();
		link_pulse = 1'b1;
		#15 link_pulse = 1'b0;
	endtask : pulse
	// spacing and data offset counted in 5 ns cycles
	task automatic send(input logic [15:0] wd, input int sp, input int d);
		for (int i = 0; i < 16; i++) begin
			pulse();
			if (wd[i]) begin
				#(d * 5 - 15) pulse();
				#((sp - d) * 5 - 15);
			end else #(sp * 5 - 15);
		end
		pulse();
	endtask : send
endmodule : anc_lp_model

/* File: verification/testbench.sv */
// self-checking bench for the receive checker
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import anc_pkg::*;
	localparam int FMIN = 10, FMAX = 100, DMIN = 40, DMAX = 80, BRK = 2000;
	logic                 ref_clk = 0, link_clk = 0, rst = 1;
	logic                 link_pulse, partner_able, ack_detect, ack_complete;
	logic                 tx_enable, restart_burst, mismatch;
	logic [WORD_BITS-1:0] rx_word, w;
	int                   fails = 0, total_checks = 0, cyc = 0, seed = 32'h856341cb;
	int                   sp_t[4] = '{90, 105, 90, 90};
	int                   d_t[4] = '{45, 50, 8, 85};
	initial forever #2.5 ref_clk = ~ref_clk;
	initial begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	anc_flp_rx_check #(.FLP_MIN(FMIN), .FLP_MAX(FMAX), .DATA_MIN(DMIN), .DATA_MAX(DMAX),
		.NLP_MIN(300), .NLP_MAX(3000), .BREAK_LEN(BRK)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .link_pulse(link_pulse),
		.partner_able(partner_able), .ack_detect(ack_detect), .ack_complete(ack_complete),
		.tx_enable(tx_enable), .restart_burst(restart_burst), .mismatch(mismatch),
		.rx_word(rx_word));
	anc_lp_model i_lp (.link_pulse(link_pulse));
	function automatic logic ok(input int sp, input int d);
		return sp >= FMIN && sp < FMAX && d >= DMIN && d < DMAX && d >= FMIN && sp - d >= FMIN;
	endfunction : ok
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic do_reset();
		@(negedge ref_clk) rst = 1;
		repeat (16) @(negedge ref_clk);
		rst = 0;
		repeat (10) @(negedge ref_clk);
	endtask : do_reset
	task automatic bursts(input int n, input int sp, input int d, input logic [15:0] wd);
		repeat (n) begin
			@(negedge ref_clk);
			i_lp.send(wd, sp, d);
			repeat (600) @(negedge ref_clk);
		end
	endtask : bursts
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 70000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		do_reset();
		check({partner_able, ack_detect, mismatch, tx_enable}, 4'b0001);
		w = 16'($random(seed)) & 16'hbffe;
		bursts(3, 90, 50, w);
		check(ack_detect, 1);
		check(partner_able, 1);
		check(rx_word, w);
		bursts(3, 90, 50, w | 16'h4000);
		check(ack_complete, 1);
		$display("test ack sequence done");
		do_reset();
		bursts(3, 90, 50, w);
		bursts(1, 90, 50, w ^ 16'h4400);
		check({mismatch, tx_enable}, 2'b10);
		for (int i = 0; i < BRK && !restart_burst; i++) @(negedge ref_clk);
		check(restart_burst, 1);
		@(negedge ref_clk);
		check({mismatch, tx_enable}, 2'b01);
		$display("test mismatch done");
		for (int k = 0; k < 4; k++) begin
			do_reset();
			bursts(3, sp_t[k], d_t[k], w);
			check(ack_detect, ok(sp_t[k], d_t[k]));
		end
		$display("test spacing table done");
		give_verdict();
	end
endmodule : testbench
